/* File: src/irq_map.svh */
// Constants for the interrupt and tick controller: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (8-bit address, 8-bit data)
// ----------------------------------------------------------------------
`define OFS_TICK_CONTROL 8'h00
`define OFS_IRQ_CONTROL 8'h01
`define OFS_COMBINED_SOURCE 8'h02
`define OFS_PRESCALER_CONFIG 8'h03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TICK_RUN_BIT 7
`define TICK_PERIOD_MSB 2
`define CHAIN_FLAG_BIT 6
`define COMBINED_FLAG_BIT 5
`define TICK_FLAG_BIT 4
`define CHAIN_EN_BIT 3
`define COMBINED_EN_BIT 2
`define TICK_EN_BIT 1
`define GLOBAL_EN_BIT 0
`define CMP_A_FLAG_BIT 5
`define CMP_P_FLAG_BIT 4
`define CMP_A_EN_BIT 1
`define CMP_P_EN_BIT 0
`define PSC_SEL_MSB 1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define REG_RESET 8'h00
`define READ_UNMAPPED 8'h00
`define TICK_BASE_EXP 8
`define TICK_CNT_W 15
`define PSC_DIV4_LAST 2'h3

`endif

/* File: src/irq_pkg.sv */
// Types shared by the interrupt and tick controller modules.
// Assumes irq_map.svh sits on the include path.
package irq_pkg;

  // ----------------------------------------------------------------------
  // Event groups and core handshake
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rx_format_err;
    logic chain_reset;
    logic tx_empty;
    logic rx_full;
  } chain_events_t;

  typedef struct packed {
    logic cmp_p;
    logic cmp_a;
  } timer_events_t;

  typedef struct packed {
    logic irq_window;
    logic stack_full;
    logic ret_irq;
    logic ret_plain;
  } core_req_t;

  typedef enum logic [1:0] {
    VEC_CHAIN = 2'h0,
    VEC_COMBINED = 2'h1,
    VEC_TICK = 2'h2
  } vector_t;

endpackage

/* File: src/tick_gen.sv */
// Tick generator: prescaler source selection and a programmable divider.
// Assumes sub_clk is an asynchronous pin; everything else is on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "irq_map.svh"

module tick_gen
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] period,
  input wire logic [1:0] src_sel,
  input wire logic sub_clk,
  output logic ovf_q
);

  logic [2:0] sub_sync_q;
  logic [2:0] sub_sync_d;
  logic [1:0] div4_q;
  logic [1:0] div4_d;
  logic [`TICK_CNT_W-1:0] cnt_q;
  logic [`TICK_CNT_W-1:0] cnt_d;
  logic ovf_d;
  logic psc_pulse;
  logic fast_cfg;
  logic [8:0] gap_q;
  logic [8:0] gap_d;

  // Last count of the interval: 2^(8+period) prescaler periods
  function automatic logic [`TICK_CNT_W-1:0] last_count(input logic [2:0] sel);
    logic [15:0] span;
    span = 16'h0001 << (`TICK_BASE_EXP + 32'(sel));
    return `TICK_CNT_W'(span - 16'h0001);
  endfunction

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  always_comb
  begin
    sub_sync_d = {sub_sync_q[1:0], sub_clk};
    div4_d = div4_q + 2'h1;
    if (src_sel == 2'h0)
      psc_pulse = 1'b1;
    else if (src_sel == 2'h1)
      psc_pulse = (div4_q == `PSC_DIV4_LAST);
    else
      psc_pulse = sub_sync_q[1] & ~sub_sync_q[2];
  end

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (!run)
      cnt_d = '0;
    else if (psc_pulse)
    begin
      if (cnt_q >= last_count(period))
      begin
        cnt_d = '0;
        ovf_d = 1'b1;
      end
      else
        cnt_d = cnt_q + `TICK_CNT_W'(1);
    end
    // Cycles since the last overflow at the fastest setting; all ones until the first overflow is seen
    fast_cfg = run && (src_sel == 2'h0) && (period == 3'h0);
    if (!fast_cfg)
      gap_d = 9'h1FF;
    else if (ovf_q)
      gap_d = 9'h000;
    else if (gap_q != 9'h1FF)
      gap_d = gap_q + 9'h001;
    else
      gap_d = gap_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sub_sync_q <= 3'h0;
      div4_q <= 2'h0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
      gap_q <= 9'h1FF;
    end
    else
    begin
      sub_sync_q <= sub_sync_d;
      div4_q <= div4_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
      gap_q <= gap_d;
    end
  end

  tick_off_a: assert property (@(posedge clk_sys) disable iff (rst) !run |=> !ovf_q)
    else $error("tick overflow while generator stopped");

  tick_span_a: assert property (@(posedge clk_sys) disable iff (rst)
    ovf_q && fast_cfg && gap_q != 9'h1FF |-> gap_q == 9'h0FF)
    else $error("shortest tick interval is not 256 system clocks");

endmodule
`default_nettype wire

/* File: src/irq_arbiter.sv */
// Fixed-priority selection among the three vectored requests.
// Assumes requests are already gated by their enables; global enable and stack state gate the grant later.
`timescale 1ns/10ps
`default_nettype none
`include "irq_map.svh"

module irq_arbiter
  import irq_pkg::*;
(
  input wire logic [2:0] req,
  output logic grant,
  output vector_t grant_id
);

  // Chain link first, combined second, tick last
  function automatic vector_t pick(input logic [2:0] r);
    if (r[VEC_CHAIN])
      return VEC_CHAIN;
    else if (r[VEC_COMBINED])
      return VEC_COMBINED;
    else
      return VEC_TICK;
  endfunction

  always_comb
  begin
    grant = |req;
    grant_id = pick(req);
  end

endmodule
`default_nettype wire

/* File: src/irq_and_tick_controller.sv */
// Interrupt request logic and tick generator for a small core.
// Assumes event inputs and core strobes are one-cycle pulses on clk_sys.
//
// Overview of operation
// - Tick generator runs only while tick_run_enable (bit 7) is 1.
// - Period code 000 gives 2^8 prescaler periods, doubling to 2^15.
// - Tick control bits 6 to 3 always read as zero.
// - Combined flag sets when either compare match flag becomes set.
// - Enabled combined request vectors if stack not full; clears flag and global.
// - Chain link flag sets on format error, reset, TX empty or RX full.
// - Chain link vectors with global and chain enable, stack not full.
// - Compare P and A matches set their own flags.
// - Timer vector needs global, source enable and combined enable.
// - Any flag rising 0 to 1 wakes the device, enables ignored.
// - A set flag holds until serviced or cleared by software.
// - Entry pushes only the program counter.
// - Return with re-enable pops and sets global; plain return pops only.
// - Prescaler source: system clock, divided by 4, or subsidiary clock.
// - Tick flag sets on overflow; vector needs global and tick enable.
// - Global enable low blocks vectoring while flags still record.
`timescale 1ns/10ps
`default_nettype none
`include "irq_map.svh"

module irq_and_tick_controller
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data_q,
  input wire chain_events_t chain_evt,
  input wire timer_events_t timer_evt,
  input wire core_req_t core_req,
  input wire logic sub_clk,
  output logic pc_push_q,
  output logic pc_pop_q,
  output vector_t vec_id_q,
  output logic wake_q
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic tick_run_enable_q, tick_run_enable_d;
  logic [2:0] tick_period_select_q, tick_period_select_d;
  logic [1:0] prescaler_source_select_q, prescaler_source_select_d;
  logic global_irq_enable_q, global_irq_enable_d;
  logic tick_irq_enable_q, tick_irq_enable_d;
  logic combined_irq_enable_q, combined_irq_enable_d;
  logic chain_link_irq_enable_q, chain_link_irq_enable_d;
  logic cmp_p_match_enable_q, cmp_p_match_enable_d;
  logic cmp_a_match_enable_q, cmp_a_match_enable_d;
  logic tick_irq_flag_q, tick_irq_flag_d;
  logic combined_irq_flag_q, combined_irq_flag_d;
  logic chain_link_irq_flag_q, chain_link_irq_flag_d;
  logic cmp_p_match_flag_q, cmp_p_match_flag_d;
  logic cmp_a_match_flag_q, cmp_a_match_flag_d;
  logic [4:0] flags_prev_q;
  logic [4:0] flags_now;
  logic [7:0] rd_data_d;
  logic pc_push_d, pc_pop_d, wake_d;
  vector_t vec_id_d;

  logic tick_ovf;
  logic [2:0] req;
  logic grant;
  vector_t grant_id;
  logic take;
  logic wr_tick, wr_ctrl, wr_src, wr_psc;
  logic set_p, set_a;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  tick_gen u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(tick_run_enable_q),
    .period(tick_period_select_q),
    .src_sel(prescaler_source_select_q),
    .sub_clk(sub_clk),
    .ovf_q(tick_ovf)
  );

  irq_arbiter u_arb (
    .req(req),
    .grant(grant),
    .grant_id(grant_id)
  );

  // ----------------------------------------------------------------------
  // Request gating and decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_tick = 1'b0;
    wr_ctrl = 1'b0;
    wr_src = 1'b0;
    wr_psc = 1'b0;
    if (wr_en && addr == `OFS_TICK_CONTROL)
      wr_tick = 1'b1;
    else if (wr_en && addr == `OFS_IRQ_CONTROL)
      wr_ctrl = 1'b1;
    else if (wr_en && addr == `OFS_COMBINED_SOURCE)
      wr_src = 1'b1;
    else if (wr_en && addr == `OFS_PRESCALER_CONFIG)
      wr_psc = 1'b1;
    req[VEC_CHAIN] = chain_link_irq_flag_q & chain_link_irq_enable_q;
    req[VEC_COMBINED] = combined_irq_flag_q & combined_irq_enable_q
      & ((cmp_p_match_flag_q & cmp_p_match_enable_q) | (cmp_a_match_flag_q & cmp_a_match_enable_q));
    req[VEC_TICK] = tick_irq_flag_q & tick_irq_enable_q;
    // One take per entry: the flag and global clear land with the push pulse
    take = grant & global_irq_enable_q & core_req.irq_window
      & ~core_req.stack_full & ~pc_push_q;
    set_p = timer_evt.cmp_p;
    set_a = timer_evt.cmp_a;
  end

  // ----------------------------------------------------------------------
  // Registers, flags and core handshake
  // ----------------------------------------------------------------------
  always_comb
  begin
    tick_run_enable_d = wr_tick ? wr_data[`TICK_RUN_BIT] : tick_run_enable_q;
    tick_period_select_d = wr_tick ? wr_data[`TICK_PERIOD_MSB:0] : tick_period_select_q;
    prescaler_source_select_d = wr_psc ? wr_data[`PSC_SEL_MSB:0] : prescaler_source_select_q;
    tick_irq_enable_d = wr_ctrl ? wr_data[`TICK_EN_BIT] : tick_irq_enable_q;
    combined_irq_enable_d = wr_ctrl ? wr_data[`COMBINED_EN_BIT] : combined_irq_enable_q;
    chain_link_irq_enable_d = wr_ctrl ? wr_data[`CHAIN_EN_BIT] : chain_link_irq_enable_q;
    cmp_p_match_enable_d = wr_src ? wr_data[`CMP_P_EN_BIT] : cmp_p_match_enable_q;
    cmp_a_match_enable_d = wr_src ? wr_data[`CMP_A_EN_BIT] : cmp_a_match_enable_q;
    global_irq_enable_d = wr_ctrl ? wr_data[`GLOBAL_EN_BIT] : global_irq_enable_q;
    if (core_req.ret_irq)
      global_irq_enable_d = 1'b1;
    if (take)
      global_irq_enable_d = 1'b0;

    // Flags hold until software or servicing clears them; a new event wins
    tick_irq_flag_d = wr_ctrl ? wr_data[`TICK_FLAG_BIT] : tick_irq_flag_q;
    combined_irq_flag_d = wr_ctrl ? wr_data[`COMBINED_FLAG_BIT] : combined_irq_flag_q;
    chain_link_irq_flag_d = wr_ctrl ? wr_data[`CHAIN_FLAG_BIT] : chain_link_irq_flag_q;
    cmp_p_match_flag_d = wr_src ? wr_data[`CMP_P_FLAG_BIT] : cmp_p_match_flag_q;
    cmp_a_match_flag_d = wr_src ? wr_data[`CMP_A_FLAG_BIT] : cmp_a_match_flag_q;
    if (take && grant_id == VEC_TICK)
      tick_irq_flag_d = 1'b0;
    if (take && grant_id == VEC_COMBINED)
      combined_irq_flag_d = 1'b0;
    if (take && grant_id == VEC_CHAIN)
      chain_link_irq_flag_d = 1'b0;
    if (tick_ovf)
      tick_irq_flag_d = 1'b1;
    if (|chain_evt)
      chain_link_irq_flag_d = 1'b1;
    if (set_p)
      cmp_p_match_flag_d = 1'b1;
    if (set_a)
      cmp_a_match_flag_d = 1'b1;
    if ((set_p && !cmp_p_match_flag_q) || (set_a && !cmp_a_match_flag_q))
      combined_irq_flag_d = 1'b1;

    flags_now = {chain_link_irq_flag_q, combined_irq_flag_q, tick_irq_flag_q,
      cmp_p_match_flag_q, cmp_a_match_flag_q};
    wake_d = |(flags_now & ~flags_prev_q);

    // Entry asks the core to push the program counter and nothing else
    pc_push_d = take;
    vec_id_d = take ? grant_id : vec_id_q;
    pc_pop_d = core_req.ret_irq | core_req.ret_plain;

    rd_data_d = `READ_UNMAPPED;
    if (rd_en && addr == `OFS_TICK_CONTROL)
      rd_data_d = {tick_run_enable_q, 4'h0, tick_period_select_q};
    else if (rd_en && addr == `OFS_IRQ_CONTROL)
      rd_data_d = {1'b0, chain_link_irq_flag_q, combined_irq_flag_q, tick_irq_flag_q,
        chain_link_irq_enable_q, combined_irq_enable_q, tick_irq_enable_q, global_irq_enable_q};
    else if (rd_en && addr == `OFS_COMBINED_SOURCE)
      rd_data_d = {2'h0, cmp_a_match_flag_q, cmp_p_match_flag_q, 2'h0,
        cmp_a_match_enable_q, cmp_p_match_enable_q};
    else if (rd_en && addr == `OFS_PRESCALER_CONFIG)
      rd_data_d = {6'h00, prescaler_source_select_q};
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // Flags clear too, so reset itself raises no wake-up
      tick_run_enable_q <= 1'b0;
      tick_period_select_q <= 3'h0;
      prescaler_source_select_q <= 2'h0;
      global_irq_enable_q <= 1'b0;
      tick_irq_enable_q <= 1'b0;
      combined_irq_enable_q <= 1'b0;
      chain_link_irq_enable_q <= 1'b0;
      cmp_p_match_enable_q <= 1'b0;
      cmp_a_match_enable_q <= 1'b0;
      tick_irq_flag_q <= 1'b0;
      combined_irq_flag_q <= 1'b0;
      chain_link_irq_flag_q <= 1'b0;
      cmp_p_match_flag_q <= 1'b0;
      cmp_a_match_flag_q <= 1'b0;
      flags_prev_q <= 5'h00;
      rd_data_q <= `REG_RESET;
      pc_push_q <= 1'b0;
      pc_pop_q <= 1'b0;
      vec_id_q <= VEC_CHAIN;
      wake_q <= 1'b0;
    end
    else
    begin
      tick_run_enable_q <= tick_run_enable_d;
      tick_period_select_q <= tick_period_select_d;
      prescaler_source_select_q <= prescaler_source_select_d;
      global_irq_enable_q <= global_irq_enable_d;
      tick_irq_enable_q <= tick_irq_enable_d;
      combined_irq_enable_q <= combined_irq_enable_d;
      chain_link_irq_enable_q <= chain_link_irq_enable_d;
      cmp_p_match_enable_q <= cmp_p_match_enable_d;
      cmp_a_match_enable_q <= cmp_a_match_enable_d;
      tick_irq_flag_q <= tick_irq_flag_d;
      combined_irq_flag_q <= combined_irq_flag_d;
      chain_link_irq_flag_q <= chain_link_irq_flag_d;
      cmp_p_match_flag_q <= cmp_p_match_flag_d;
      cmp_a_match_flag_q <= cmp_a_match_flag_d;
      flags_prev_q <= flags_now;
      rd_data_q <= rd_data_d;
      pc_push_q <= pc_push_d;
      pc_pop_q <= pc_pop_d;
      vec_id_q <= vec_id_d;
      wake_q <= wake_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  entry_clears_global_a: assert property (pc_push_q |-> !global_irq_enable_q)
    else $error("global enable still set after entry");

  stack_full_block_a: assert property (core_req.stack_full |=> !pc_push_q)
    else $error("entry taken with stack full");

  global_block_a: assert property (!global_irq_enable_q |=> !pc_push_q)
    else $error("entry taken with global enable low");

  return_with_irq_reenable_reenable_a: assert property (core_req.ret_irq && !take |=> global_irq_enable_q && pc_pop_q)
    else $error("return with re-enable did not set global enable");

  ret_plain_keep_a: assert property (core_req.ret_plain && !core_req.ret_irq && !take && !wr_ctrl
    |=> pc_pop_q && $stable(global_irq_enable_q))
    else $error("plain return changed global enable");

  combined_set_a: assert property ((set_p || set_a) |=> cmp_p_match_flag_q || cmp_a_match_flag_q)
    else $error("compare match not recorded");

  chain_flag_set_a: assert property (|chain_evt |=> chain_link_irq_flag_q)
    else $error("chain link event not recorded");

  flag_hold_a: assert property (tick_irq_flag_q && !take && !wr_ctrl |=> tick_irq_flag_q)
    else $error("tick flag dropped without clear");

  wake_edge_a: assert property ($rose(chain_link_irq_flag_q) |=> wake_q)
    else $error("flag rise gave no wake-up");

  reserved_zero_a: assert property (rd_en && addr == `OFS_TICK_CONTROL |=> rd_data_q[6:3] == 4'h0)
    else $error("reserved tick control bits read nonzero");

  // ----------------------------------------------------------------------
  // Flag setting, service and priority
  // ----------------------------------------------------------------------
  combined_rise_a: assert property ((set_p && !cmp_p_match_flag_q) || (set_a && !cmp_a_match_flag_q)
    |=> combined_irq_flag_q)
    else $error("source rise missed combined flag");

  tick_flag_set_a: assert property (tick_ovf |=> tick_irq_flag_q)
    else $error("tick overflow not recorded");

  chain_first_a: assert property (take && req[VEC_CHAIN] |=> vec_id_q == VEC_CHAIN)
    else $error("chain request lost priority");

  chain_clear_a: assert property (take && grant_id == VEC_CHAIN && !(|chain_evt)
    |=> !chain_link_irq_flag_q)
    else $error("chain flag kept after entry");

  combined_clear_a: assert property (take && grant_id == VEC_COMBINED && !set_p && !set_a
    |=> !combined_irq_flag_q)
    else $error("combined flag kept after entry");

  push_once_a: assert property (pc_push_q |=> !pc_push_q)
    else $error("entry pulse longer than one cycle");

  timer_gate_a: assert property (take && grant_id == VEC_COMBINED
    |-> combined_irq_enable_q && (cmp_p_match_enable_q || cmp_a_match_enable_q))
    else $error("timer vector taken without its enables");

endmodule
`default_nettype wire

/* File: bench/core_model.sv */
// Core model: program sequencer stack that follows push and pop pulses.
// Assumes the bench pulses each return command for exactly one cycle.
`timescale 1ns/10ps
`default_nettype none

module core_model
  import irq_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pc_push_q,
  input wire logic pc_pop_q,
  input wire logic window_on,
  input wire logic ret_irq_cmd,
  input wire logic ret_plain_cmd,
  output core_req_t core_req
);
  int depth_q;

  // ----------------------------------------------------------------------
  // Stack depth
  // ----------------------------------------------------------------------
  // Only the return address is stacked, so one entry per push
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      depth_q <= 0;
    else
      depth_q <= depth_q + int'(pc_push_q) - int'(pc_pop_q);
  end

  // ----------------------------------------------------------------------
  // Requests to the controller
  // ----------------------------------------------------------------------
  // A full stack holds entries back until a return pops one
  always_comb
  begin
    core_req.irq_window = window_on;
    core_req.stack_full = depth_q >= DEPTH;
    core_req.ret_irq = ret_irq_cmd;
    core_req.ret_plain = ret_plain_cmd;
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Bench for the interrupt and tick controller: registers, events, vectors, ticks.
// Assumes irq_pkg, irq_map.svh and core_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "irq_map.svh"

module tb;
  import irq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data_q;
  chain_events_t chain_evt = '0;
  timer_events_t timer_evt = '0;
  core_req_t core_req;
  logic sub_clk = 1'b0;
  logic sub_on = 1'b0;
  logic [1:0] sub_div = 2'h0;
  logic pc_push_q;
  logic pc_pop_q;
  logic wake_q;
  vector_t vec_id_q;
  vector_t last_vec = VEC_CHAIN;
  logic window_on = 1'b0;
  logic ret_irq_cmd = 1'b0;
  logic ret_plain_cmd = 1'b0;
  logic [31:0] rng = 32'h24;
  chain_events_t ce;
  timer_events_t te;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_push = 0;
  int n_pop = 0;
  int n_wake = 0;
  int t_wake = 0;
  int ev_cyc = 0;
  int w;
  int b;
  int t0;

  irq_and_tick_controller u_irq_and_tick_controller (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .chain_evt(chain_evt),
    .timer_evt(timer_evt), .core_req(core_req), .sub_clk(sub_clk), .pc_push_q(pc_push_q),
    .pc_pop_q(pc_pop_q), .vec_id_q(vec_id_q), .wake_q(wake_q));

  core_model #(.DEPTH(2)) u_core_model (.clk_sys(clk_sys), .rst(rst), .pc_push_q(pc_push_q),
    .pc_pop_q(pc_pop_q), .window_on(window_on), .ret_irq_cmd(ret_irq_cmd),
    .ret_plain_cmd(ret_plain_cmd), .core_req(core_req));

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Monitors and subsidiary clock (period of four system clocks)
  // ----------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    sub_div <= sub_div + 2'h1;
    sub_clk <= sub_on & sub_div[1];
    if (pc_push_q === 1'b1)
    begin
      n_push <= n_push + 1;
      last_vec <= vec_id_q;
    end
    if (pc_pop_q === 1'b1)
      n_pop <= n_pop + 1;
    if (wake_q === 1'b1)
    begin
      n_wake <= n_wake + 1;
      t_wake <= cyc;
    end
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Sub clock runs at a quarter of the system clock, same as the divide-by-4 path
  function automatic int tick_len(input logic [1:0] sel, input logic [2:0] per);
    return (1 << (`TICK_BASE_EXP + per)) * ((sel == 2'h0) ? 1 : 4);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rd_data_q, exp);
  endtask

  // Bounded wait for a monitor counter to move away from its base
  task automatic wait_cnt(ref int cnt, input int base, input int lim);
    int i;
    i = 0;
    while (cnt == base && i < lim)
    begin
      @(posedge clk_sys);
      i++;
    end
    #1;
  endtask

  task automatic pulse(input chain_events_t c, input timer_events_t t);
    @(posedge clk_sys);
    chain_evt <= c;
    timer_evt <= t;
    @(posedge clk_sys);
    ev_cyc = cyc;
    chain_evt <= '0;
    timer_evt <= '0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic got_push(input vector_t v, input logic [7:0] e);
    wait_cnt(n_push, b, 8);
    chk(n_push, b + 1);
    chk(last_vec, v);
    rd(`OFS_IRQ_CONTROL, e);
  endtask

  // Own base count, so the caller's push base in b survives the return
  task automatic ret(input logic reenable);
    int pb;
    pb = n_pop;
    @(posedge clk_sys);
    ret_irq_cmd <= reenable;
    ret_plain_cmd <= ~reenable;
    @(posedge clk_sys);
    ret_irq_cmd <= 1'b0;
    ret_plain_cmd <= 1'b0;
    wait_cnt(n_pop, pb, 4);
    chk(n_pop, pb + 1);
  endtask

  task automatic tick_case(input logic [1:0] sel, input logic [2:0] per);
    sub_on <= sel[1];
    wr(`OFS_PRESCALER_CONFIG, {6'h00, sel});
    wr(`OFS_TICK_CONTROL, {1'b1, 4'h0, per});
    w = n_wake;
    wait_cnt(n_wake, w, 40000);
    t0 = t_wake;
    wr(`OFS_IRQ_CONTROL, 8'h00);
    w = n_wake;
    wait_cnt(n_wake, w, 40000);
    chk(t_wake - t0, tick_len(sel, per));
    wr(`OFS_TICK_CONTROL, 8'h00);
    wr(`OFS_IRQ_CONTROL, 8'h00);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // ----------------------------------------------------------------------
    // Reset values, unimplemented bits, unmapped place
    // ----------------------------------------------------------------------
    for (int i = 0; i < 5; i++)
      rd(8'(i), 8'h00);
    wr(`OFS_TICK_CONTROL, 8'hFF);
    rd(`OFS_TICK_CONTROL, 8'h87);
    wr(`OFS_PRESCALER_CONFIG, 8'hFF);
    rd(`OFS_PRESCALER_CONFIG, 8'h03);
    for (int i = 0; i < 4; i++)
      wr(8'(i), 8'h00);
    // ----------------------------------------------------------------------
    // Events: one-hot chain causes first, then random mixes
    // ----------------------------------------------------------------------
    for (int i = 0; i < 12; i++)
    begin
      rng = xorshift(rng);
      ce = (i < 4) ? chain_events_t'(4'h1 << i) : chain_events_t'(rng[3:0]);
      te = timer_events_t'(rng[5:4]);
      w = n_wake;
      pulse(ce, te);
      rd(`OFS_IRQ_CONTROL, {1'b0, |ce, |te, 5'h00});
      rd(`OFS_COMBINED_SOURCE, {2'h0, te.cmp_a, te.cmp_p, 4'h0});
      chk(n_wake - w, (ce != '0 || te != '0) ? 1 : 0);
      if (ce != '0 || te != '0)
        chk(t_wake - ev_cyc, 2);
      wr(`OFS_IRQ_CONTROL, 8'h00);
      wr(`OFS_COMBINED_SOURCE, 8'h00);
    end
    // Flag preset by software keeps the event from waking the core; the preset itself wakes it
    w = n_wake;
    wr(`OFS_IRQ_CONTROL, 8'h40);
    repeat (3) @(posedge clk_sys);
    chk(n_wake, w + 1);
    w = n_wake;
    pulse(4'h1, 2'h0);
    chk(n_wake, w);
    // ----------------------------------------------------------------------
    // Vectoring, priority, stack full, returns
    // ----------------------------------------------------------------------
    window_on <= 1'b1;
    wr(`OFS_COMBINED_SOURCE, 8'h11);
    b = n_push;
    wr(`OFS_IRQ_CONTROL, 8'h7E);
    repeat (8) @(posedge clk_sys);
    chk(n_push, b);
    rd(`OFS_IRQ_CONTROL, 8'h7E);
    wr(`OFS_IRQ_CONTROL, 8'h7F);
    got_push(VEC_CHAIN, 8'h3E);
    b = n_push;
    wr(`OFS_IRQ_CONTROL, 8'h3F);
    got_push(VEC_COMBINED, 8'h1E);
    rd(`OFS_COMBINED_SOURCE, 8'h11);
    b = n_push;
    wr(`OFS_IRQ_CONTROL, 8'h1F);
    repeat (8) @(posedge clk_sys);
    chk(n_push, b);
    ret(1'b0);
    got_push(VEC_TICK, 8'h0E);
    wr(`OFS_COMBINED_SOURCE, 8'h00);
    ret(1'b0);
    rd(`OFS_IRQ_CONTROL, 8'h0E);
    ret(1'b1);
    rd(`OFS_IRQ_CONTROL, 8'h0F);
    window_on <= 1'b0;
    wr(`OFS_IRQ_CONTROL, 8'h00);
    // ----------------------------------------------------------------------
    // Tick periods across every prescaler source
    // ----------------------------------------------------------------------
    for (int i = 0; i < 5; i++)
    begin
      rng = xorshift(rng);
      tick_case(i < 4 ? 2'(i) : rng[1:0], i < 4 ? 3'(i % 2) : {1'b0, rng[3:2]});
    end
    tick_case(2'h0, 3'h4);
    // Mid-run reset must clear what software left behind
    wr(`OFS_IRQ_CONTROL, 8'h7F);
    wr(`OFS_TICK_CONTROL, 8'h85);
    wr(`OFS_COMBINED_SOURCE, 8'h33);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
      rd(8'(i), 8'h00);
    w = n_wake;
    repeat (600) @(posedge clk_sys);
    chk(n_wake, w);
    report_and_stop();
  end
endmodule
`default_nettype wire
